// ### rtl/ctd_decoder.sv
// Control-transfer and operand-addressing decoder with APB registers.
// Assumes bytes arrive from same-clock prefetch logic with valid/ready.
//
// Operation
// - Jump forms: near, short, far, indirect
// - Near return, optional immediate stack adjust
// - Far return, optional immediate stack adjust
// - Direction bit one means register is destination
// - Width bit one means word operation
// - Mode 11 selects register, no memory
// - Mode 00 means zero displacement
// - Mode 01 one byte, sign-extended
// - Mode 10 two bytes, high above low
// - Operand-select picks base and index
// - Mode 00 select 110 is direct address
// - Displacement before immediate data
// - Sign and width pick immediate form
// - Count source: one or count low byte
// - Repeat z bit compared with zero flag
// - Segment override prefix replaces default segment
// - Register and segment code mapping
// - Flag word bit layout
// - Above/below unsigned, greater/less signed
`timescale 1ns/1ps
module ctd_decoder (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Instruction byte stream
	input  wire logic        BYTE_VALID,
	input  wire logic [7:0]  BYTE_DATA,
	output logic             BYTE_READY,
	// Decoded instruction
	output logic             DEC_VALID,
	output logic [4:0]       DEC_KIND,
	output logic [7:0]       DEC_OPCODE,
	output logic [1:0]       DEC_MOD,
	output logic [2:0]       DEC_REG,
	output logic [2:0]       DEC_RM,
	output logic             DEC_TO_REG,
	output logic             DEC_WORD,
	output logic             DEC_MEM,
	output logic             DEC_REG_HIGH,
	output logic [1:0]       DEC_BASE_SEL,
	output logic [1:0]       DEC_INDEX_SEL,
	output logic [1:0]       DEC_SEG_SEL,
	output logic [15:0]      DEC_DISP,
	output logic [15:0]      DEC_IMM,
	output logic [15:0]      DEC_SEGMENT,
	output logic             DEC_SP_ADD,
	output logic             DEC_PUSH_RET,
	output logic [7:0]       DEC_SHIFT_COUNT,
	output logic             DEC_REP_GO,
	output logic             DEC_TAKEN
);
	typedef enum logic [2:0] {S_OPC, S_MODRM, S_DISP, S_IMM, S_SEG} ctd_state_e;

	ctd_state_e        state;
	ctd_state_e        next_state;
	ctd_pkg::ctd_kind_e kind;
	ctd_pkg::ctd_kind_e next_kind;
	logic [7:0]  opcode;
	logic [1:0]  mod_f;
	logic [2:0]  reg_f;
	logic [2:0]  rm_f;
	logic        has_modrm;
	logic [1:0]  disp_left, imm_left, seg_left;
	logic [1:0]  next_disp, next_imm, next_seg;
	logic        next_modrm, disp_two, imm_two, next_disp_two, next_imm_two;
	logic [15:0] disp, imm, segval;
	logic        ovr_on, rep_on, rep_z;
	logic [1:0]  ovr_seg;
	logic        ovr_pend, rep_pend, rep_pz, opc_take;
	logic [1:0]  ovr_pseg;
	logic        is_prefix, finish, take;
	logic        ctrl_en;
	logic [15:0] flag_word, count_reg, dec_cnt;
	logic        apb_wr, apb_rd;

	assign take       = BYTE_VALID && BYTE_READY;
	assign BYTE_READY = ctrl_en;
	assign opc_take   = take && state == S_OPC && !is_prefix;

	////////////////////////////////////////////////////////////////////////
	// Byte sequencing
	always_comb begin
		next_state    = state;
		next_kind     = kind;
		next_modrm    = 1'b0;
		next_disp     = disp_left;
		next_imm      = imm_left;
		next_seg      = seg_left;
		next_disp_two = disp_two;
		next_imm_two  = imm_two;
		is_prefix     = 1'b0;
		finish        = 1'b0;
		if (take) begin
			case (state)
				S_OPC: begin
					next_kind     = ctd_pkg::K_OTHER;
					next_disp     = 2'h0;
					next_imm      = 2'h0;
					next_seg      = 2'h0;
					next_disp_two = 1'b0;
					next_imm_two  = 1'b0;
					if (BYTE_DATA[7:5] == 3'h1 && BYTE_DATA[2:0] == 3'h6)
						is_prefix = 1'b1;
					else if (BYTE_DATA[7:1] == 7'h79)
						is_prefix = 1'b1;
					else if (BYTE_DATA == ctd_pkg::OP_CALL_NEAR) begin
						next_kind     = ctd_pkg::K_CALL_NEAR;
						next_disp     = 2'h2;
						next_disp_two = 1'b1;
					end else if (BYTE_DATA == ctd_pkg::OP_CALL_FAR) begin
						next_kind    = ctd_pkg::K_CALL_FAR;
						next_imm     = 2'h2;
						next_imm_two = 1'b1;
						next_seg     = 2'h2;
					end else if (BYTE_DATA == ctd_pkg::OP_JMP_NEAR) begin
						next_kind     = ctd_pkg::K_JMP_NEAR;
						next_disp     = 2'h2;
						next_disp_two = 1'b1;
					end else if (BYTE_DATA == ctd_pkg::OP_JMP_SHORT) begin
						next_kind = ctd_pkg::K_JMP_SHORT;
						next_disp = 2'h1;
					end else if (BYTE_DATA == ctd_pkg::OP_JMP_FAR) begin
						next_kind    = ctd_pkg::K_JMP_FAR;
						next_imm     = 2'h2;
						next_imm_two = 1'b1;
						next_seg     = 2'h2;
					end else if (BYTE_DATA[7:4] == 4'h7) begin
						next_kind = ctd_pkg::K_COND_JMP;
						next_disp = 2'h1;
					end else if (BYTE_DATA[7:1] == ctd_pkg::OP_RET_NEARI[7:1]) begin
						next_kind    = ctd_pkg::K_RET_NEAR;
						next_imm     = BYTE_DATA[0] ? 2'h0 : 2'h2;
						next_imm_two = 1'b1;
					end else if (BYTE_DATA[7:1] == ctd_pkg::OP_RET_FARI[7:1]) begin
						next_kind    = ctd_pkg::K_RET_FAR;
						next_imm     = BYTE_DATA[0] ? 2'h0 : 2'h2;
						next_imm_two = 1'b1;
					end else if (BYTE_DATA == ctd_pkg::OP_GRP_FF) begin
						next_kind  = ctd_pkg::K_MODRM_OP;
						next_modrm = 1'b1;
					// immediate form from sign and width
					end else if (BYTE_DATA[7:2] == 6'h20) begin
						next_kind    = ctd_pkg::K_IMM_OP;
						next_modrm   = 1'b1;
						next_imm_two = BYTE_DATA[1:0] == 2'h1;
						next_imm     = next_imm_two ? 2'h2 : 2'h1;
					end else if (BYTE_DATA[7:2] == 6'h34) begin
						next_kind  = ctd_pkg::K_SHIFT_OP;
						next_modrm = 1'b1;
					end else if (BYTE_DATA[7:6] == 2'h0 && !BYTE_DATA[2]) begin
						next_kind  = ctd_pkg::K_MODRM_OP;
						next_modrm = 1'b1;
					end else if (BYTE_DATA[7:4] == 4'ha && (BYTE_DATA[3:1] == 3'h2 || BYTE_DATA[3:1] == 3'h3 ||
						BYTE_DATA[3:2] == 2'h3 || BYTE_DATA[3:1] == 3'h5))
						next_kind = ctd_pkg::K_STRING_OP;
				end
				S_MODRM: begin
					if (opcode == ctd_pkg::OP_GRP_FF) begin
						case (BYTE_DATA[5:3])
							ctd_pkg::RF_CALL_NEAR: next_kind = ctd_pkg::K_CALL_IND_NEAR;
							ctd_pkg::RF_CALL_FAR:  next_kind = ctd_pkg::K_CALL_IND_FAR;
							ctd_pkg::RF_JMP_NEAR:  next_kind = ctd_pkg::K_JMP_IND_NEAR;
							ctd_pkg::RF_JMP_FAR:   next_kind = ctd_pkg::K_JMP_IND_FAR;
							default:               next_kind = ctd_pkg::K_MODRM_OP;
						endcase
					end
					case (BYTE_DATA[7:6])
						ctd_pkg::MOD_NODISP: next_disp_two = BYTE_DATA[2:0] == ctd_pkg::RM_DIRECT;
						ctd_pkg::MOD_DISP16: next_disp_two = 1'b1;
						default:             next_disp_two = 1'b0;
					endcase
					if (next_disp_two)
						next_disp = 2'h2;
					else if (BYTE_DATA[7:6] == ctd_pkg::MOD_DISP8)
						next_disp = 2'h1;
					else
						next_disp = 2'h0;
				end
				S_DISP:  next_disp = disp_left - 2'h1;
				S_IMM:   next_imm  = imm_left - 2'h1;
				S_SEG:   next_seg  = seg_left - 2'h1;
				default: next_disp = 2'h0;
			endcase
			if (is_prefix)
				next_state = S_OPC;
			else if (next_modrm)
				next_state = S_MODRM;
			else if (next_disp != 2'h0)
				next_state = S_DISP;
			else if (next_imm != 2'h0)
				next_state = S_IMM;
			else if (next_seg != 2'h0)
				next_state = S_SEG;
			else begin
				next_state = S_OPC;
				finish     = 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state     <= S_OPC;
			kind      <= ctd_pkg::K_OTHER;
			disp_left <= 2'h0;
			imm_left  <= 2'h0;
			seg_left  <= 2'h0;
			disp_two  <= 1'b0;
			imm_two   <= 1'b0;
			DEC_VALID <= 1'b0;
		end else begin
			state     <= next_state;
			kind      <= next_kind;
			disp_left <= next_disp;
			imm_left  <= next_imm;
			seg_left  <= next_seg;
			disp_two  <= next_disp_two;
			imm_two   <= next_imm_two;
			DEC_VALID <= finish;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field capture
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			opcode    <= 8'h00;
			mod_f     <= ctd_pkg::MOD_REG;
			reg_f     <= 3'h0;
			rm_f      <= 3'h0;
			has_modrm <= 1'b0;
			disp      <= 16'h0000;
			imm       <= 16'h0000;
			segval    <= 16'h0000;
		end else if (take) begin
			case (state)
				S_OPC: if (!is_prefix) begin
					opcode    <= BYTE_DATA;
					has_modrm <= next_modrm;
					mod_f     <= ctd_pkg::MOD_REG;
					reg_f     <= 3'h0;
					rm_f      <= 3'h0;
					disp      <= 16'h0000;
					imm       <= 16'h0000;
					segval    <= 16'h0000;
				end
				S_MODRM: begin
					mod_f <= BYTE_DATA[7:6];
					reg_f <= BYTE_DATA[5:3];
					rm_f  <= BYTE_DATA[2:0];
				end
				S_DISP: if (disp_left == 2'h2 || !disp_two)
					disp <= disp_two ? {8'h00, BYTE_DATA} : {{8{BYTE_DATA[7]}}, BYTE_DATA};
				else
					disp[15:8] <= BYTE_DATA;
				S_IMM: if (imm_left == 2'h2 || !imm_two)
					imm <= imm_two ? {8'h00, BYTE_DATA} : {{8{BYTE_DATA[7] & opcode[1]}}, BYTE_DATA};
				else
					imm[15:8] <= BYTE_DATA;
				S_SEG: if (seg_left == 2'h2)
					segval[7:0] <= BYTE_DATA;
				else
					segval[15:8] <= BYTE_DATA;
				default: disp <= disp;
			endcase
		end
	end

	// Prefixes wait as pending, then apply from the opcode byte until the next opcode byte,
	// so they still stand while the decoded instruction is presented
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ovr_pend <= 1'b0;
			ovr_pseg <= ctd_pkg::SEG_DATA;
			rep_pend <= 1'b0;
			rep_pz   <= 1'b0;
			ovr_on   <= 1'b0;
			ovr_seg  <= ctd_pkg::SEG_DATA;
			rep_on   <= 1'b0;
			rep_z    <= 1'b0;
		end else if (is_prefix) begin
			if (BYTE_DATA[7:5] == 3'h1) begin
				ovr_pend <= 1'b1;
				ovr_pseg <= BYTE_DATA[4:3];
			end else begin
				rep_pend <= 1'b1;
				rep_pz   <= BYTE_DATA[0];
			end
		end else if (opc_take) begin
			ovr_on   <= ovr_pend;
			ovr_seg  <= ovr_pseg;
			rep_on   <= rep_pend;
			rep_z    <= rep_pz;
			ovr_pend <= 1'b0;
			rep_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoded outputs
	assign DEC_KIND   = kind;
	assign DEC_OPCODE = opcode;
	assign DEC_MOD    = mod_f;
	assign DEC_REG    = reg_f;
	assign DEC_RM     = rm_f;
	assign DEC_DISP   = disp;
	assign DEC_IMM    = imm;
	assign DEC_SEGMENT = segval;
	assign DEC_TO_REG = opcode[1];
	assign DEC_WORD   = opcode[0];
	assign DEC_MEM    = has_modrm && mod_f != ctd_pkg::MOD_REG;
	// byte codes 100-111 are high halves
	assign DEC_REG_HIGH = !opcode[0] && reg_f[2];
	assign DEC_SP_ADD = (kind == ctd_pkg::K_RET_NEAR || kind == ctd_pkg::K_RET_FAR) && !opcode[0];
	// calls push the return address first
	assign DEC_PUSH_RET = kind inside {ctd_pkg::K_CALL_NEAR, ctd_pkg::K_CALL_FAR,
		ctd_pkg::K_CALL_IND_NEAR, ctd_pkg::K_CALL_IND_FAR};
	assign DEC_SHIFT_COUNT = opcode[1] ? count_reg[7:0] : 8'h01;
	// compare strings continue while zero flag matches z
	assign DEC_REP_GO = rep_on && (!(opcode[3:1] == 3'h3 || opcode[3:1] == 3'h7) ||
		flag_word[ctd_pkg::FB_ZRO] == rep_z);

	// base and index from operand select
	always_comb begin
		DEC_BASE_SEL  = ctd_pkg::BASE_NONE;
		DEC_INDEX_SEL = ctd_pkg::IDX_NONE;
		if (DEC_MEM && !(mod_f == ctd_pkg::MOD_NODISP && rm_f == ctd_pkg::RM_DIRECT)) begin
			case (rm_f)
				3'h0, 3'h1, 3'h7: DEC_BASE_SEL = ctd_pkg::BASE_BREG;
				3'h2, 3'h3, 3'h6: DEC_BASE_SEL = ctd_pkg::BASE_FRMP;
				default:          DEC_BASE_SEL = ctd_pkg::BASE_NONE;
			endcase
			if (rm_f[2:1] != 2'h3)
				DEC_INDEX_SEL = rm_f[0] ? ctd_pkg::IDX_DST : ctd_pkg::IDX_SRC;
		end
	end

	// frame-pointer operands default to the stack segment
	assign DEC_SEG_SEL = ovr_on ? ovr_seg :
		(DEC_BASE_SEL == ctd_pkg::BASE_FRMP) ? ctd_pkg::SEG_STACK : ctd_pkg::SEG_DATA;

	// unsigned uses carry/zero, signed uses sign/overflow
	always_comb begin
		case (opcode[3:1])
			3'h0:    DEC_TAKEN = flag_word[ctd_pkg::FB_OVF];
			3'h1:    DEC_TAKEN = flag_word[ctd_pkg::FB_CRY];
			3'h2:    DEC_TAKEN = flag_word[ctd_pkg::FB_ZRO];
			3'h3:    DEC_TAKEN = flag_word[ctd_pkg::FB_CRY] | flag_word[ctd_pkg::FB_ZRO];
			3'h4:    DEC_TAKEN = flag_word[ctd_pkg::FB_SGN];
			3'h5:    DEC_TAKEN = flag_word[ctd_pkg::FB_PAR];
			3'h6:    DEC_TAKEN = flag_word[ctd_pkg::FB_SGN] ^ flag_word[ctd_pkg::FB_OVF];
			default: DEC_TAKEN = flag_word[ctd_pkg::FB_ZRO] |
				(flag_word[ctd_pkg::FB_SGN] ^ flag_word[ctd_pkg::FB_OVF]);
		endcase
		DEC_TAKEN = (kind == ctd_pkg::K_COND_JMP) && (DEC_TAKEN ^ opcode[0]);
	end

	////////////////////////////////////////////////////////////////////////
	// APB registers, zero wait states
	assign apb_wr  = PSEL && PENABLE && PWRITE;
	assign apb_rd  = PSEL && PENABLE && !PWRITE;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !(PADDR inside {ctd_pkg::OFF_CTRL, ctd_pkg::OFF_FLAGS,
		ctd_pkg::OFF_COUNT, ctd_pkg::OFF_STATUS, ctd_pkg::OFF_DISP, ctd_pkg::OFF_IMM});

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_en   <= ctd_pkg::CTRL_RST;
			flag_word <= ctd_pkg::FLAGS_RST;
			count_reg <= ctd_pkg::COUNT_RST;
		end else if (apb_wr) begin
			case (PADDR)
				ctd_pkg::OFF_CTRL:  ctrl_en <= PWDATA[0];
				// flag word layout, undefined bits zero
				ctd_pkg::OFF_FLAGS: flag_word <= PWDATA[15:0] & ctd_pkg::FLAGS_MASK;
				ctd_pkg::OFF_COUNT: count_reg <= PWDATA[15:0];
				default:            count_reg <= count_reg;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			dec_cnt <= 16'h0000;
		else if (finish)
			dec_cnt <= dec_cnt + 16'h0001;
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE) begin
			case (PADDR)
				ctd_pkg::OFF_CTRL:   PRDATA <= {31'h0, ctrl_en};
				ctd_pkg::OFF_FLAGS:  PRDATA <= {16'h0000, flag_word};
				ctd_pkg::OFF_COUNT:  PRDATA <= {16'h0000, count_reg};
				ctd_pkg::OFF_STATUS: PRDATA <= {dec_cnt, 5'h0, state, 3'h0, kind};
				ctd_pkg::OFF_DISP:   PRDATA <= {16'h0000, disp};
				ctd_pkg::OFF_IMM:    PRDATA <= {16'h0000, imm};
				default:             PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_ret_imm(logic [7:0] op);
		take && BYTE_DATA == op && state == S_OPC ##1 take ##1 take;
	endsequence

	a_short_sext: assert property (@(posedge MCLK) disable iff (!RST_B)
		DEC_VALID && kind == ctd_pkg::K_JMP_SHORT |-> DEC_DISP[15:8] == {8{DEC_DISP[7]}})
		else $error("short jump displacement not sign-extended");
	a_near_ret_imm: assert property (@(posedge MCLK) disable iff (!RST_B)
		s_ret_imm(ctd_pkg::OP_RET_NEARI) |=> DEC_VALID && DEC_SP_ADD &&
		DEC_IMM == {$past(BYTE_DATA), $past(BYTE_DATA, 2)})
		else $error("near return immediate wrong");
	a_far_ret_imm: assert property (@(posedge MCLK) disable iff (!RST_B)
		s_ret_imm(ctd_pkg::OP_RET_FARI) |=> DEC_VALID && kind == ctd_pkg::K_RET_FAR &&
		DEC_IMM == {$past(BYTE_DATA), $past(BYTE_DATA, 2)})
		else $error("far return immediate wrong");
	a_reg_nomem: assert property (@(posedge MCLK) disable iff (!RST_B)
		DEC_VALID && mod_f == ctd_pkg::MOD_REG |-> !DEC_MEM)
		else $error("register operand made memory access");
	a_mod0_zero: assert property (@(posedge MCLK) disable iff (!RST_B)
		DEC_VALID && has_modrm && mod_f == ctd_pkg::MOD_NODISP && rm_f != ctd_pkg::RM_DIRECT |-> DEC_DISP == 16'h0000)
		else $error("mode 00 displacement not zero");
	a_direct_ea: assert property (@(posedge MCLK) disable iff (!RST_B)
		DEC_VALID && has_modrm && mod_f == ctd_pkg::MOD_NODISP && rm_f == ctd_pkg::RM_DIRECT |->
		DEC_BASE_SEL == ctd_pkg::BASE_NONE && DEC_INDEX_SEL == ctd_pkg::IDX_NONE)
		else $error("direct address added a base");
	a_shift_cnt: assert property (@(posedge MCLK) disable iff (!RST_B)
		DEC_VALID && kind == ctd_pkg::K_SHIFT_OP |-> DEC_SHIFT_COUNT == (opcode[1] ? count_reg[7:0] : 8'h01))
		else $error("shift count source wrong");
	a_flag_write: assert property (@(posedge MCLK) disable iff (!RST_B)
		apb_wr && PADDR == ctd_pkg::OFF_FLAGS |=> flag_word == ($past(PWDATA[15:0]) & ctd_pkg::FLAGS_MASK))
		else $error("flag word layout wrong");
	a_below_cond: assert property (@(posedge MCLK) disable iff (!RST_B)
		DEC_VALID && opcode == 8'h72 |-> DEC_TAKEN == flag_word[ctd_pkg::FB_CRY])
		else $error("below condition not on carry");
endmodule : ctd_decoder

// ### rtl/ctd_pkg.sv
// Constants for the control-transfer and operand decoder.
// Assumes one clock domain and a zero-wait APB register port.
package ctd_pkg;
	// APB register byte offsets
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_FLAGS  = 12'h004;
	localparam logic [11:0] OFF_COUNT  = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00c;
	localparam logic [11:0] OFF_DISP   = 12'h010;
	localparam logic [11:0] OFF_IMM    = 12'h014;
	// Reset values
	localparam logic        CTRL_RST   = 1'h1;
	localparam logic [15:0] FLAGS_RST  = 16'h0000;
	localparam logic [15:0] COUNT_RST  = 16'h0000;
	// Flag word layout; undefined bits read zero
	localparam int          FB_OVF = 11;
	localparam int          FB_DIR = 10;
	localparam int          FB_IEN = 9;
	localparam int          FB_TRP = 8;
	localparam int          FB_SGN = 7;
	localparam int          FB_ZRO = 6;
	localparam int          FB_AUX = 4;
	localparam int          FB_PAR = 2;
	localparam int          FB_CRY = 0;
	localparam logic [15:0] FLAGS_MASK = 16'h0fd5;
	// Opcodes
	localparam logic [7:0] OP_CALL_NEAR = 8'he8;
	localparam logic [7:0] OP_CALL_FAR  = 8'h9a;
	localparam logic [7:0] OP_JMP_NEAR  = 8'he9;
	localparam logic [7:0] OP_JMP_SHORT = 8'heb;
	localparam logic [7:0] OP_JMP_FAR   = 8'hea;
	localparam logic [7:0] OP_GRP_FF    = 8'hff;
	localparam logic [7:0] OP_RET_NEAR  = 8'hc3;
	localparam logic [7:0] OP_RET_NEARI = 8'hc2;
	localparam logic [7:0] OP_RET_FAR   = 8'hcb;
	localparam logic [7:0] OP_RET_FARI  = 8'hca;
	// Register-field codes in the 0xFF group
	localparam logic [2:0] RF_CALL_NEAR = 3'h2;
	localparam logic [2:0] RF_CALL_FAR  = 3'h3;
	localparam logic [2:0] RF_JMP_NEAR  = 3'h4;
	localparam logic [2:0] RF_JMP_FAR   = 3'h5;
	// Addressing-mode field and the direct-address select
	localparam logic [1:0] MOD_NODISP = 2'h0;
	localparam logic [1:0] MOD_DISP8  = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_REG    = 2'h3;
	localparam logic [2:0] RM_DIRECT  = 3'h6;
	// Segment codes
	localparam logic [1:0] SEG_EXTRA = 2'h0;
	localparam logic [1:0] SEG_CODE  = 2'h1;
	localparam logic [1:0] SEG_STACK = 2'h2;
	localparam logic [1:0] SEG_DATA  = 2'h3;
	// Base and index selects of the address calculator
	localparam logic [1:0] BASE_NONE = 2'h0;
	localparam logic [1:0] BASE_BREG = 2'h1;
	localparam logic [1:0] BASE_FRMP = 2'h2;
	localparam logic [1:0] IDX_NONE  = 2'h0;
	localparam logic [1:0] IDX_SRC   = 2'h1;
	localparam logic [1:0] IDX_DST   = 2'h2;
	typedef enum logic [4:0] {
		K_OTHER, K_CALL_NEAR, K_CALL_FAR, K_CALL_IND_NEAR, K_CALL_IND_FAR,
		K_JMP_NEAR, K_JMP_SHORT, K_JMP_FAR, K_JMP_IND_NEAR, K_JMP_IND_FAR,
		K_RET_NEAR, K_RET_FAR, K_COND_JMP, K_MODRM_OP, K_IMM_OP, K_SHIFT_OP, K_STRING_OP
	} ctd_kind_e;
endpackage : ctd_pkg

// ### verif/ctd_prefetch_model.sv
// Prefetch queue model that feeds instruction bytes to the decoder.
// Assumes the bench queues bytes; one byte moves on each valid and ready edge.
`timescale 1ns/1ps
module ctd_prefetch_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Byte stream
	input  wire logic       ready,
	output logic            valid,
	output logic [7:0]      data
);
	logic [7:0] q[$];
	initial begin
		valid = 1'b0;
		data  = 8'h00;
	end
	// Random stalls; an idle line shows inverted stale data
	always @(posedge clk) begin
		if (valid && ready)
			void'(q.pop_front());
		if (!rst_b)
			valid <= 1'b0;
		else if (!valid || ready) begin
			if (q.size() != 0 && $urandom_range(3) != 0) begin
				valid <= 1'b1;
				data  <= q[0];
			end else begin
				valid <= 1'b0;
				data  <= ~data;
			end
		end
	end
endmodule : ctd_prefetch_model

// ### verif/tb.sv
// Self-checking bench for the control-transfer and operand decoder.
// Assumes a zero-wait APB slave and the prefetch model on the byte stream.
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, bvalid, bready, dvalid, to_reg, word, mem, rhigh, sp_add, push_ret, go, taken, er;
	logic [7:0]  bdata, opcode, scount;
	logic [4:0]  kind;
	logic [1:0]  dmod, base, idx, seg;
	logic [2:0]  dreg, drm;
	logic [15:0] disp, imm, segw;
	int          err_count = 0, cmp_count = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	ctd_prefetch_model pf (.clk(mclk), .rst_b(rst_b), .ready(bready), .valid(bvalid), .data(bdata));
	ctd_decoder dut (.MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.BYTE_VALID(bvalid), .BYTE_DATA(bdata), .BYTE_READY(bready), .DEC_VALID(dvalid), .DEC_KIND(kind),
		.DEC_OPCODE(opcode), .DEC_MOD(dmod), .DEC_REG(dreg), .DEC_RM(drm), .DEC_TO_REG(to_reg), .DEC_WORD(word),
		.DEC_MEM(mem), .DEC_REG_HIGH(rhigh), .DEC_BASE_SEL(base), .DEC_INDEX_SEL(idx), .DEC_SEG_SEL(seg),
		.DEC_DISP(disp), .DEC_IMM(imm), .DEC_SEGMENT(segw), .DEC_SP_ADD(sp_add), .DEC_PUSH_RET(push_ret),
		.DEC_SHIFT_COUNT(scount), .DEC_REP_GO(go), .DEC_TAKEN(taken));
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task run(input logic [7:0] b[$]);
		foreach (b[i])
			pf.q.push_back(b[i]);
		do
			@(negedge mclk);
		while (dvalid !== 1'b1);
	endtask : run
	function automatic logic [15:0] xdisp(logic [1:0] m, logic [2:0] r, logic [7:0] lo, logic [7:0] hi);
		if (m == 2'h1)
			return {{8{lo[7]}}, lo};
		if (m == 2'h2 || (m == 2'h0 && r == 3'h6))
			return {hi, lo};
		return 16'h0000;
	endfunction : xdisp
	// Base select in the upper pair, index select in the lower pair
	function automatic logic [3:0] xbi(logic [1:0] m, logic [2:0] r);
		case (r)
			3'h0: return 4'h5;
			3'h1: return 4'h6;
			3'h2: return 4'h9;
			3'h3: return 4'ha;
			3'h4: return 4'h1;
			3'h5: return 4'h2;
			3'h6: return (m == 2'h0) ? 4'h0 : 4'h8;
			default: return 4'h4;
		endcase
	endfunction : xbi
	task finish_test();
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin : main
		logic [7:0]  lo, hi, m, op;
		logic [7:0]  q[$];
		logic [15:0] fl, cnt;
		int          s;
		void'($urandom(81870));
		repeat (2) @(posedge mclk);
		chk({bready, dvalid}, 2'h2, "reset outputs");
		rst_b <= 1'b1;
		@(posedge mclk);
		fl = $urandom;
		cnt = $urandom;
		apb(1'b1, ctd_pkg::OFF_FLAGS, {16'h0, fl});
		apb(1'b0, ctd_pkg::OFF_FLAGS, 32'h0);
		chk(rd, {16'h0, fl & ctd_pkg::FLAGS_MASK}, "flag word");
		apb(1'b0, 12'h020, 32'h0);
		chk(er, 1'b1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, ctd_pkg::OFF_CTRL, 32'h0);
		chk(bready, 1'b0, "disabled");
		apb(1'b1, ctd_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, ctd_pkg::OFF_COUNT, {16'h0, cnt});
		for (int i = 0; i < 4; i++) begin
			op = (i[1] ? 8'hc8 : 8'hc0) | (i[0] ? 8'h02 : 8'h03);
			lo = $urandom;
			hi = $urandom;
			if (op[0])
				run('{op});
			else
				run('{op, lo, hi});
			chk(kind, i[1] ? ctd_pkg::K_RET_FAR : ctd_pkg::K_RET_NEAR, "ret kind");
			chk(sp_add, !op[0], "ret adjust");
			if (!op[0])
				chk(imm, {hi, lo}, "ret imm");
		end
		lo = $urandom | 8'h80;
		hi = $urandom;
		run('{8'he9, lo, hi});
		chk({kind, disp}, {ctd_pkg::K_JMP_NEAR, hi, lo}, "near jump");
		run('{8'heb, lo});
		chk({kind, disp}, {ctd_pkg::K_JMP_SHORT, 8'hff, lo}, "short jump");
		run('{8'hea, lo, hi, hi, lo});
		chk({kind, imm, segw}, {ctd_pkg::K_JMP_FAR, hi, lo, lo, hi}, "far jump");
		apb(1'b0, ctd_pkg::OFF_IMM, 32'h0);
		chk(rd, {16'h0, hi, lo}, "imm register");
		run('{8'he8, lo, hi});
		chk({kind, push_ret}, {ctd_pkg::K_CALL_NEAR, 1'b1}, "near call");
		run('{8'h9a, lo, hi, hi, lo});
		chk({kind, push_ret}, {ctd_pkg::K_CALL_FAR, 1'b1}, "far call");
		for (int r = 2; r < 6; r++) begin
			run('{8'hff, {2'h3, r[2:0], 3'h1}});
			chk(kind, r < 4 ? r + 1 : r + 4, "indirect kind");
			chk(push_ret, r < 4, "ret push");
		end
		for (int i = 0; i < 40; i++) begin
			op = $urandom_range(3);
			m = (i < 4) ? {i[1:0], 6'h16} : $urandom;
			lo = $urandom;
			hi = $urandom;
			s = $urandom_range(4);
			q = {};
			if (s < 4)
				q.push_back({3'h1, s[1:0], 3'h6});
			q.push_back(op);
			q.push_back(m);
			if (m[7:6] == 2'h1)
				q.push_back(lo);
			if (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6)) begin
				q.push_back(lo);
				q.push_back(hi);
			end
			run(q);
			chk({to_reg, word}, op[1:0], "direction width");
			chk({opcode, dmod, dreg, drm}, {op, m}, "fields");
			chk(rhigh, !op[0] && m[5], "byte high");
			chk(mem, m[7:6] != 2'h3, "memory");
			if (m[7:6] != 2'h3) begin
				chk(disp, xdisp(m[7:6], m[2:0], lo, hi), "disp");
				chk({base, idx}, xbi(m[7:6], m[2:0]), "base index");
				chk(seg, s < 4 ? s[1:0] : (xbi(m[7:6], m[2:0]) > 4'h7 ? 2'h2 : 2'h3), "segment");
			end
		end
		run('{8'h81, 8'h40, lo, hi, lo});
		chk({disp, imm}, {{8{lo[7]}}, lo, lo, hi}, "disp then imm");
		run('{8'h83, 8'hc0, lo});
		chk(imm, {{8{lo[7]}}, lo}, "imm sext");
		run('{8'hd0, 8'hc0});
		chk(scount, 8'h01, "count one");
		run('{8'hd2, 8'hc0});
		chk(scount, cnt[7:0], "count reg");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, ctd_pkg::OFF_FLAGS, i ? 32'h0080 : 32'h0041);
			run('{8'h72, lo});
			chk(taken, !i, "below");
			run('{8'h7c, lo});
			chk(taken, i, "less");
			run('{8'hf3, 8'ha6});
			chk(go, !i, "repeat z1");
			run('{8'hf2, 8'ha6});
			chk(go, i, "repeat z0");
		end
		finish_test();
	end
endmodule : tb
